// >>> hw/wake_pkg.sv
// Purpose: Shared constants for the wake-on-LAN configuration and wake output block.
// Assumes: Registers are 16 bits wide (status and mask 8 bits), placed in the low half of 32-bit APB words.
// Notes:   Byte address of a register is four times its index.
package wake_pkg;

    // ==========================================================================
    // Register indices and bus geometry
    // ==========================================================================
    localparam int          ADDR_W          = 12;
    localparam int          REG_W           = 16;
    localparam logic [9:0]  CONFIG_INDEX    = 10'h134;
    localparam logic [9:0]  STATUS_INDEX    = 10'h135;
    localparam logic [9:0]  PASSWORD0_INDEX = 10'h139;
    localparam logic [9:0]  PASSWORD1_INDEX = 10'h13a;
    localparam logic [9:0]  PASSWORD2_INDEX = 10'h13b;
    localparam logic [9:0]  MASK_INDEX      = 10'h1f0;

    typedef enum {
        SEL_NONE,
        SEL_CONFIG,
        SEL_STATUS,
        SEL_PASSWORD0,
        SEL_PASSWORD1,
        SEL_PASSWORD2,
        SEL_MASK
    } reg_sel_t;

    // ==========================================================================
    // receive_wake_config fields
    // ==========================================================================
    localparam int          CFG_MAGIC_EN    = 0;
    localparam int          CFG_PATTERN_EN  = 1;
    localparam int          CFG_BCAST_EN    = 2;
    localparam int          CFG_UCAST_EN    = 4;
    localparam int          CFG_PASSWORD_EN = 5;
    localparam int          CFG_ENHANCED    = 7;
    localparam int          CFG_LEVEL_MODE  = 8;
    localparam int          CFG_STRETCH_LO  = 9;
    localparam int          CFG_STRETCH_HI  = 10;
    localparam int          CFG_CLEAR       = 11;
    localparam logic [15:0] CONFIG_RESET    = 16'h0004;
    localparam logic [15:0] CONFIG_WMASK    = 16'h07b7;

    // ==========================================================================
    // receive_wake_status fields (mask register uses the same layout)
    // ==========================================================================
    localparam int          STS_MAGIC       = 0;
    localparam int          STS_PATTERN     = 1;
    localparam int          STS_BCAST       = 2;
    localparam int          STS_UCAST       = 4;
    localparam int          STS_ATTACK      = 5;
    localparam int          STS_BAD_CRC     = 6;
    localparam int          STS_SFD_ERR     = 7;
    localparam logic [7:0]  STATUS_RESET    = 8'h00;
    localparam logic [7:0]  STATUS_USED     = 8'hf7;
    localparam logic [7:0]  MASK_RESET      = 8'h00;
    localparam logic [15:0] PASSWORD_RESET  = 16'h0000;

    // ==========================================================================
    // Wake pulse lengths in clock cycles, selected by the two-bit stretch field
    // ==========================================================================
    localparam int          PULSE_CYCLES_0  = 8;
    localparam int          PULSE_CYCLES_1  = 16;
    localparam int          PULSE_CYCLES_2  = 32;
    localparam int          PULSE_CYCLES_3  = 64;
    localparam int          PULSE_CNT_W     = 7;

endpackage : wake_pkg

// >>> hw/password_match.sv
// Purpose: Compares the password carried by a magic packet with the stored one.
// Assumes: All inputs come from the same clock domain and are stable.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module password_match (
    input  wire logic [15:0] wordLow,
    input  wire logic [15:0] wordMid,
    input  wire logic [15:0] wordHigh,
    input  wire logic [47:0] received,
    output logic             match
);

    logic [47:0] stored;

    // ==========================================================================
    // Comparison
    // ==========================================================================
    // The upper word holds bits 47 down to 32.
    always_comb begin
        stored = {wordHigh, wordMid, wordLow};  // see RULE11
        match  = (stored == received);           // see RULE11
    end

endmodule : password_match

// >>> hw/wake_output_driver.sv
// Purpose: Drives the wake output either as a stretched pulse or as a held level.
// Assumes: trigger and clearLevel are one-cycle pulses on mclk.
// Notes:   A new trigger during a pulse restarts the pulse at full length.
`timescale 1ns/1ps
module wake_output_driver (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       trigger,
    input  wire logic       levelMode,
    input  wire logic [1:0] stretch,
    input  wire logic       clearLevel,
    output logic            wakeOut
);

    logic [wake_pkg::PULSE_CNT_W-1:0] count_reg;
    logic [wake_pkg::PULSE_CNT_W-1:0] count_next;
    logic [wake_pkg::PULSE_CNT_W-1:0] pulseLen;
    logic                             wake_reg;
    logic                             wake_next;

    // ==========================================================================
    // Next state
    // ==========================================================================
    always_comb begin
        case (stretch)  // see RULE1
            2'b00:   pulseLen = wake_pkg::PULSE_CNT_W'(wake_pkg::PULSE_CYCLES_0);
            2'b01:   pulseLen = wake_pkg::PULSE_CNT_W'(wake_pkg::PULSE_CYCLES_1);
            2'b10:   pulseLen = wake_pkg::PULSE_CNT_W'(wake_pkg::PULSE_CYCLES_2);
            default: pulseLen = wake_pkg::PULSE_CNT_W'(wake_pkg::PULSE_CYCLES_3);
        endcase
        count_next = count_reg;
        wake_next  = wake_reg;
        if (levelMode) begin
            count_next = '0;
            if (trigger) begin
                wake_next = 1'b1;                // see RULE2
            end else if (clearLevel) begin
                wake_next = 1'b0;                // see RULE3
            end
        end else if (trigger) begin
            count_next = pulseLen - 1'b1;        // see RULE1
            wake_next  = 1'b1;
        end else if (count_reg != '0) begin
            count_next = count_reg - 1'b1;
        end else begin
            wake_next  = 1'b0;                   // see RULE1
        end
    end

    // ==========================================================================
    // Registers
    // ==========================================================================
    always_ff @(posedge mclk) begin
        if (rst) begin
            count_reg <= '0;
            wake_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            wake_reg  <= wake_next;
        end
    end

    assign wakeOut = wake_reg;

endmodule : wake_output_driver

// >>> hw/wake_on_lan_config_output.sv
// Purpose: Wake-on-LAN receive configuration, status flags and wake output.
// Assumes: Frame classification inputs come from receive logic on mclk.
// Notes:   APB slave answers with pready in the first access cycle.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps

//
// Overview of operation
// RULE1: pulse mode drives wake for 8, 16, 32 or 64 cycles by stretch field.
// RULE2: level select bit 8 set holds wake asserted until software clears it.
// RULE3: writing clear bit 11 drops level wake; bit reads zero; no pulse effect.
// RULE4: enhanced enable bit 7 gates wake detection, CRC check and timestamp flag.
// RULE5: password enable bit 5 requires a matching password inside magic packets.
// RULE6: unicast enable bit 4 lets valid unicast frames raise a wake.
// RULE7: broadcast enable bit 2, reset to one, lets broadcast frames raise a wake.
// RULE8: pattern enable bit 1 lets pattern-matching frames raise a wake.
// RULE9: magic enable bit 0 lets valid magic packets raise a wake.
// RULE10: each receive event latches a status flag that clears after being read.
// RULE11: password is 48 bits in three 16-bit words, high word bits 47 to 32.
// RULE12: wake only when enhanced features on and an enabled condition just seen.
module wake_on_lan_config_output #(
    parameter int ADDR_W = wake_pkg::ADDR_W
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              frameDone,
    input  wire logic              frameUnicast,
    input  wire logic              frameBroadcast,
    input  wire logic              framePattern,
    input  wire logic              frameMagic,
    input  wire logic              frameBadCrc,
    input  wire logic              frameSfdError,
    input  wire logic [47:0]       framePassword,
    input  wire logic              frameStart,
    output logic                   wakeOut,
    output logic                   irq,
    output logic                   timestampFlag
);

    // ==========================================================================
    // Declarations
    // ==========================================================================
    logic [15:0]       config_reg;
    logic [15:0]       config_next;
    logic [7:0]        status_reg;
    logic [7:0]        status_next;
    logic [7:0]        mask_reg;
    logic [7:0]        mask_next;
    logic [15:0]       pwd0_reg;
    logic [15:0]       pwd0_next;
    logic [15:0]       pwd1_reg;
    logic [15:0]       pwd1_next;
    logic [15:0]       pwd2_reg;
    logic [15:0]       pwd2_next;
    logic [31:0]       rdata_reg;
    logic [31:0]       rdata_next;
    logic              ready_reg;
    logic              ready_next;
    logic              err_reg;
    logic              err_next;
    logic [7:0]        snap_reg;
    logic [7:0]        snap_next;
    logic              irq_reg;
    logic              irq_next;
    logic              stamp_reg;
    logic              stamp_next;
    logic              trig_reg;
    logic              trig_next;
    logic              clear_reg;
    logic              clear_next;
    logic              setupPhase;
    logic              accessDone;
    logic              writeDone;
    logic              readDone;
    wake_pkg::reg_sel_t setupSel;
    wake_pkg::reg_sel_t accessSel;
    logic [15:0]       wdata16;
    logic              passwordOk;
    logic              enhanced;
    logic              goodFrame;
    logic              magicValid;
    logic              attack;
    logic [7:0]        events;
    logic              wakeCause;
    logic              wakeLine;

    // ==========================================================================
    // Address decode
    // ==========================================================================
    // Shared by the read path in setup and the write path in access.
    function automatic wake_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] addr);
        logic [9:0] index;
        index = addr[11:2];
        if (addr[1:0] != 2'b00) begin
            decode = wake_pkg::SEL_NONE;
        end else if (index == wake_pkg::CONFIG_INDEX) begin
            decode = wake_pkg::SEL_CONFIG;
        end else if (index == wake_pkg::STATUS_INDEX) begin
            decode = wake_pkg::SEL_STATUS;
        end else if (index == wake_pkg::PASSWORD0_INDEX) begin
            decode = wake_pkg::SEL_PASSWORD0;
        end else if (index == wake_pkg::PASSWORD1_INDEX) begin
            decode = wake_pkg::SEL_PASSWORD1;
        end else if (index == wake_pkg::PASSWORD2_INDEX) begin
            decode = wake_pkg::SEL_PASSWORD2;
        end else if (index == wake_pkg::MASK_INDEX) begin
            decode = wake_pkg::SEL_MASK;
        end else begin
            decode = wake_pkg::SEL_NONE;
        end
    endfunction : decode

    // Applies byte strobes of the low two lanes over an old 16-bit value.
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] data,
                                          input logic [1:0]  strb);
        merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    endfunction : merge

    always_comb begin
        setupPhase = psel && !penable;
        accessDone = psel && penable && ready_reg;
        writeDone  = accessDone && pwrite;
        readDone   = accessDone && !pwrite;
        setupSel   = decode(paddr);
        accessSel  = decode(paddr);
        wdata16    = pwdata[15:0];
    end

    // ==========================================================================
    // Frame evaluation
    // ==========================================================================
    password_match u_password_match (
        .wordLow  (pwd0_reg),
        .wordMid  (pwd1_reg),
        .wordHigh (pwd2_reg),
        .received (framePassword),
        .match    (passwordOk)
    );

    always_comb begin
        enhanced   = config_reg[wake_pkg::CFG_ENHANCED];                  // see RULE4
        goodFrame  = frameDone && enhanced && !frameBadCrc && !frameSfdError;
        magicValid = goodFrame && frameMagic &&
                     (!config_reg[wake_pkg::CFG_PASSWORD_EN] || passwordOk); // see RULE5
        attack     = goodFrame && frameMagic &&
                     config_reg[wake_pkg::CFG_PASSWORD_EN] && !passwordOk;   // see RULE5
        events                        = 8'h00;
        events[wake_pkg::STS_MAGIC]   = magicValid;                        // see RULE10
        events[wake_pkg::STS_PATTERN] = goodFrame && framePattern;         // see RULE10
        events[wake_pkg::STS_BCAST]   = goodFrame && frameBroadcast;       // see RULE10
        events[wake_pkg::STS_UCAST]   = goodFrame && frameUnicast;         // see RULE10
        events[wake_pkg::STS_ATTACK]  = attack;                            // see RULE10
        events[wake_pkg::STS_BAD_CRC] = frameDone && enhanced && frameBadCrc; // see RULE4
        events[wake_pkg::STS_SFD_ERR] = frameDone && enhanced && frameSfdError;
        wakeCause =
            (config_reg[wake_pkg::CFG_UCAST_EN]   && events[wake_pkg::STS_UCAST])   || // see RULE6
            (config_reg[wake_pkg::CFG_BCAST_EN]   && events[wake_pkg::STS_BCAST])   || // see RULE7
            (config_reg[wake_pkg::CFG_PATTERN_EN] && events[wake_pkg::STS_PATTERN]) || // see RULE8
            (config_reg[wake_pkg::CFG_MAGIC_EN]   && events[wake_pkg::STS_MAGIC]);     // see RULE9
    end

    // ==========================================================================
    // Register file next state
    // ==========================================================================
    always_comb begin
        config_next = config_reg;
        mask_next   = mask_reg;
        pwd0_next   = pwd0_reg;
        pwd1_next   = pwd1_reg;
        pwd2_next   = pwd2_reg;
        clear_next  = 1'b0;
        // The clear bit is never stored, so it always reads back as zero.
        config_next[wake_pkg::CFG_CLEAR] = 1'b0;                           // see RULE3
        if (writeDone) begin
            case (accessSel)
                wake_pkg::SEL_CONFIG: begin
                    config_next = merge(config_reg, wdata16, pstrb[1:0]) &
                                  wake_pkg::CONFIG_WMASK;
                    clear_next  = pstrb[1] && wdata16[wake_pkg::CFG_CLEAR]; // see RULE3
                end
                wake_pkg::SEL_MASK: begin
                    mask_next = pstrb[0] ? (wdata16[7:0] & wake_pkg::STATUS_USED)
                                         : mask_reg;
                end
                wake_pkg::SEL_PASSWORD0: begin
                    pwd0_next = merge(pwd0_reg, wdata16, pstrb[1:0]);      // see RULE11
                end
                wake_pkg::SEL_PASSWORD1: begin
                    pwd1_next = merge(pwd1_reg, wdata16, pstrb[1:0]);      // see RULE11
                end
                wake_pkg::SEL_PASSWORD2: begin
                    pwd2_next = merge(pwd2_reg, wdata16, pstrb[1:0]);      // see RULE11
                end
                default: begin
                    config_next[wake_pkg::CFG_CLEAR] = 1'b0;
                end
            endcase
        end
    end

    // ==========================================================================
    // Status flags, interrupt and wake trigger next state
    // ==========================================================================
    // Only the bits returned by the read are cleared, and a new event in the
    // clearing cycle sets its flag again, so no event is lost.
    always_comb begin
        status_next = status_reg;
        if (readDone && accessSel == wake_pkg::SEL_STATUS) begin
            status_next = status_reg & ~snap_reg;                          // see RULE10
        end
        status_next = status_next | events;                                // see RULE10
        irq_next    = |(status_next & mask_reg);
        trig_next   = enhanced && wakeCause;                               // see RULE12
        stamp_next  = enhanced && frameStart;                              // see RULE4
    end

    // ==========================================================================
    // APB answer next state
    // ==========================================================================
    // Read data is taken in the setup cycle so that pready and prdata come
    // straight from flops in the first access cycle.
    always_comb begin
        ready_next = setupPhase;
        err_next   = 1'b0;
        rdata_next = rdata_reg;
        snap_next  = snap_reg;
        if (setupPhase) begin
            rdata_next = 32'h0000_0000;
            snap_next  = 8'h00;
            case (setupSel)
                wake_pkg::SEL_CONFIG: begin
                    rdata_next[15:0] = config_reg;
                end
                wake_pkg::SEL_STATUS: begin
                    rdata_next[7:0] = status_reg;
                    snap_next       = status_reg;
                end
                wake_pkg::SEL_PASSWORD0: begin
                    rdata_next[15:0] = pwd0_reg;
                end
                wake_pkg::SEL_PASSWORD1: begin
                    rdata_next[15:0] = pwd1_reg;
                end
                wake_pkg::SEL_PASSWORD2: begin
                    rdata_next[15:0] = pwd2_reg;
                end
                wake_pkg::SEL_MASK: begin
                    rdata_next[7:0] = mask_reg;
                end
                default: begin
                    err_next         = 1'b1;
                end
            endcase
        end else if (!psel) begin
            rdata_next = 32'h0000_0000;
        end
    end

    // ==========================================================================
    // Registers
    // ==========================================================================
    always_ff @(posedge mclk) begin
        if (rst) begin
            config_reg <= wake_pkg::CONFIG_RESET;                          // see RULE7
            status_reg <= wake_pkg::STATUS_RESET;
            mask_reg   <= wake_pkg::MASK_RESET;
            pwd0_reg   <= wake_pkg::PASSWORD_RESET;
            pwd1_reg   <= wake_pkg::PASSWORD_RESET;
            pwd2_reg   <= wake_pkg::PASSWORD_RESET;
            rdata_reg  <= 32'h0000_0000;
            ready_reg  <= 1'b0;
            err_reg    <= 1'b0;
            snap_reg   <= 8'h00;
            irq_reg    <= 1'b0;
            stamp_reg  <= 1'b0;
            trig_reg   <= 1'b0;
            clear_reg  <= 1'b0;
        end else begin
            config_reg <= config_next;
            status_reg <= status_next;
            mask_reg   <= mask_next;
            pwd0_reg   <= pwd0_next;
            pwd1_reg   <= pwd1_next;
            pwd2_reg   <= pwd2_next;
            rdata_reg  <= rdata_next;
            ready_reg  <= ready_next;
            err_reg    <= err_next;
            snap_reg   <= snap_next;
            irq_reg    <= irq_next;
            stamp_reg  <= stamp_next;
            trig_reg   <= trig_next;
            clear_reg  <= clear_next;
        end
    end

    // ==========================================================================
    // Wake output
    // ==========================================================================
    wake_output_driver u_wake_output_driver (
        .mclk       (mclk),
        .rst        (rst),
        .trigger    (trig_reg),                                            // see RULE12
        .levelMode  (config_reg[wake_pkg::CFG_LEVEL_MODE]),                // see RULE2
        .stretch    (config_reg[wake_pkg::CFG_STRETCH_HI:wake_pkg::CFG_STRETCH_LO]),
        .clearLevel (clear_reg),                                           // see RULE3
        .wakeOut    (wakeLine)
    );

    // ==========================================================================
    // Outputs
    // ==========================================================================
    always_comb begin
        prdata        = rdata_reg;
        pready        = ready_reg;
        pslverr       = err_reg;
        wakeOut       = wakeLine;
        irq           = irq_reg;
        timestampFlag = stamp_reg;
    end

endmodule : wake_on_lan_config_output

// >>> test/wake_asserts.sv
// Purpose: Port checks for the wake block.
// Assumes: One clock; rst synchronous, active high.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ps
module wake_asserts (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic frameDone,
    input wire logic frameStart,
    input wire logic wakeOut,
    input wire logic timestampFlag
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    ready_first_a: assert property (psel && !penable |=> pready) else $error("ready late");
    ready_access_a: assert property (pready |-> psel && penable) else $error("ready early");
    ready_once_a: assert property (pready |=> !pready) else $error("ready held");
    err_gate_a: assert property (pslverr |-> pready) else $error("error alone");
    err_once_a: assert property (pslverr |=> !pslverr) else $error("error held");
    wake_cause_a: assert property ($rose(wakeOut) |-> $past(frameDone, 2))
        else $error("wake without frame");
    wake_min_a: assert property ($rose(wakeOut) |-> wakeOut [*8])
        else $error("wake too short");
    stamp_src_a: assert property (timestampFlag |-> $past(frameStart))
        else $error("stray timestamp");
endmodule : wake_asserts

// >>> test/frame_source.sv
// Purpose: Link partner model handing finished frames to the block.
// Assumes: Called from the bench just after a clock edge.
// Notes:   Between frames the qualifiers show the inverse of the last frame.
`timescale 1ns/1ps
module frame_source (
    input  wire logic   mclk,
    output logic        frameDone,
    output logic        frameStart,
    output logic [5:0]  kind,
    output logic [47:0] framePassword
);
    initial begin
        frameDone = 1'b0;
        frameStart = 1'b0;
        kind = 6'h3f;
        framePassword = '1;
    end
    task automatic send(input logic [5:0] k, input logic [47:0] pw);
        @(posedge mclk) frameStart <= 1'b1;
        @(posedge mclk) frameStart <= 1'b0;
        frameDone <= 1'b1;
        kind <= k;
        framePassword <= pw;
        @(posedge mclk) frameDone <= 1'b0;
        kind <= ~k;
        framePassword <= ~pw;
    endtask : send
endmodule : frame_source

// >>> test/tb_wake_on_lan_config_output.sv
// Purpose: Self-checking bench for the wake block.
// Assumes: APB master by tasks; frames from the partner model.
// Notes:   Reads queue expectations; a monitor compares them.
`timescale 1ns/1ps
module tb_wake_on_lan_config_output;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, x = 32'h4faaf484;
    logic        pready, pslverr, frameDone, frameStart, wakeOut, irq, tsFlag;
    logic [5:0]  kind;
    logic [47:0] framePassword, pw;
    logic [32:0] expQ[$];
    int          fails = 0, checked = 0, n, stamps = 0;
    localparam logic [9:0] CF = wake_pkg::CONFIG_INDEX, ST = wake_pkg::STATUS_INDEX;
    always #50 mclk = ~mclk;
    function automatic logic [31:0] rnd(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : rnd
    task automatic cmp(input logic [32:0] e, logic [32:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask : cmp
    task automatic apb(input logic w, logic [9:0] i, logic [15:0] d);
        @(posedge mclk) psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {16'h0, d};
        @(posedge mclk) penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [9:0] i, logic [32:0] e);
        expQ.push_back(e);
        apb(1'b0, i, 16'h0);
    endtask : rd
    task automatic fr(input logic [5:0] k, logic [47:0] p, logic e);
        u_src.send(k, p);
        @(posedge mclk) #1 cmp(33'(e), 33'(wakeOut));
    endtask : fr
    task automatic summarize();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    always @(posedge mclk) begin
        if (psel && penable && pready && !pwrite && expQ.size() > 0)
            cmp(expQ.pop_front(), {pslverr, prdata});
    end
    always @(posedge mclk) stamps <= stamps + tsFlag;
    initial begin
        #3000000 fails++;
        summarize();
    end
    // ==========================================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        rd(CF, 33'(wake_pkg::CONFIG_RESET));
        rd(10'h3ff, 33'h1_0000_0000);
        apb(1'b1, CF, 16'h0017);
        fr(6'h02, 48'h0, 1'b0);
        rd(ST, 33'h0);
        apb(1'b1, wake_pkg::MASK_INDEX, 16'h0001);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, CF, 16'(16'h0081 | (s << 9)));
            fr(6'h08, 48'h0, 1'b1);
            for (n = 0; wakeOut === 1'b1 && n < 100; n++)
                @(posedge mclk) #1;
            cmp(33'(wake_pkg::PULSE_CYCLES_0 << s), 33'(n));
            cmp(33'h1, 33'(irq));
            rd(ST, 33'h1);
            repeat (2) @(posedge mclk) #1;
            cmp(33'h0, 33'(irq));
        end
        apb(1'b1, CF, 16'h0196);
        fr(6'h01, 48'h0, 1'b1);
        repeat (70) @(posedge mclk);
        #1 cmp(33'h1, 33'(wakeOut));
        apb(1'b1, CF, 16'h0996);
        repeat (3) @(posedge mclk) #1;
        cmp(33'h0, 33'(wakeOut));
        rd(CF, 33'h0196);
        fr(6'h04, 48'h0, 1'b1);
        apb(1'b1, CF, 16'h0996);
        rd(ST, 33'h12);
        apb(1'b1, CF, 16'h0093);
        fr(6'h02, 48'h0, 1'b0);
        cmp(33'h0, 33'(irq));
        rd(ST, 33'h4);
        x = rnd(x);
        pw = {x[15:0], rnd(x)};
        apb(1'b1, wake_pkg::PASSWORD0_INDEX, pw[15:0]);
        apb(1'b1, wake_pkg::PASSWORD1_INDEX, pw[31:16]);
        apb(1'b1, wake_pkg::PASSWORD2_INDEX, pw[47:32]);
        apb(1'b1, CF, 16'h00a1);
        fr(6'h08, pw, 1'b1);
        repeat (10) @(posedge mclk);
        fr(6'h08, {pw[15:0], pw[31:16], pw[47:32]}, 1'b0);
        fr(6'h38, pw, 1'b0);
        rd(ST, 33'he1);
        #1 cmp(33'd10, 33'(stamps));
        summarize();
    end
    frame_source u_src (.mclk, .frameDone, .frameStart, .kind, .framePassword);
    wake_on_lan_config_output u_dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .frameDone,
        .frameUnicast(kind[0]), .frameBroadcast(kind[1]), .framePattern(kind[2]),
        .frameMagic(kind[3]), .frameBadCrc(kind[4]), .frameSfdError(kind[5]),
        .framePassword, .frameStart, .wakeOut, .irq, .timestampFlag(tsFlag));
endmodule : tb_wake_on_lan_config_output
bind wake_on_lan_config_output wake_asserts u_chk (.mclk, .rst, .psel, .penable,
    .pready, .pslverr, .frameDone, .frameStart, .wakeOut, .timestampFlag);
